// ==== logic/pmlc_defines.vh ====
// Purpose: constants of the auxiliary PHY control block
// Assumes: 100 MHz mclk
// Notes:   offsets are management register numbers
`ifndef PMLC_DEFINES_VH
`define PMLC_DEFINES_VH

// ==========================================================
// Timing
`define PMLC_CLK_HZ        34'd100000000
`define PMLC_CLK_MHZ       17'd100
`define PMLC_DPD_DELAY_S   34'd32
`define PMLC_DPD_CYC       (`PMLC_DPD_DELAY_S * `PMLC_CLK_HZ)
`define PMLC_XO_HUNT_US    17'd100
`define PMLC_XO_HUNT_CYC   (`PMLC_XO_HUNT_US * `PMLC_CLK_MHZ)
`define PMLC_PRE_ONES      6'd32

// ==========================================================
// Register numbers
`define PMLC_REG_CTRL      5'h00
`define PMLC_REG_STAT      5'h01
`define PMLC_REG_ID_HI     5'h02
`define PMLC_REG_ID_LO     5'h03
`define PMLC_REG_ADV       5'h04
`define PMLC_REG_LPA       5'h05
`define PMLC_REG_EXP       5'h06
`define PMLC_REG_NPT       5'h07
`define PMLC_REG_LPNP      5'h08
`define PMLC_REG_XOVER     5'h13
`define PMLC_REG_LED       5'h14
`define PMLC_REG_PWR       5'h18

// ==========================================================
// Fields and reset values
`define PMLC_CTL_RESET     15
`define PMLC_CTL_SPEED     13
`define PMLC_CTL_ANEN      12
`define PMLC_CTL_ISOLATE   10
`define PMLC_CTL_RESTART   9
`define PMLC_CTL_RST_VAL   16'h3100
`define PMLC_CTL_WMASK     16'h7d80
`define PMLC_STAT_CONST    16'h7809
`define PMLC_STAT_LINK     2
`define PMLC_XO_AUTO       9
`define PMLC_XO_FORCE      8
`define PMLC_XO_RST_VAL    16'h0200
`define PMLC_LED_RST_VAL   16'h0010
`define PMLC_PWR_RST_VAL   16'h0000
`define PMLC_PWR_SEL_HI    8
`define PMLC_PWR_SEL_LO    4
`define PMLC_PWR_DPD       0
`define PMLC_ADV_RST_VAL   16'h01e1
`define PMLC_NPT_RST_VAL   16'h2001

// ==========================================================
// Status pin event selectors
`define PMLC_EV_LINK       3'h0
`define PMLC_EV_ACT        3'h1
`define PMLC_EV_TX         3'h2
`define PMLC_EV_RX         3'h3
`define PMLC_EV_COL        3'h4
`define PMLC_EV_SPEED      3'h5
`define PMLC_EV_DUPLEX     3'h6

// Management frame opcodes
`define PMLC_OP_WRITE      2'h1
`define PMLC_OP_READ       2'h2

`endif

// ==== logic/pmlc_phy_aux.v ====
// Purpose: crossover select, deep power-down, strap/status pins and
//          management register slave of a 10/100 PHY
// Assumes: all inputs synchronous to mclk; mdc far slower than mclk
// Notes:   rst is the power-on / hardware reset
// Function
// RULE1: With auto crossover off, the strap is ignored and the force bit picks straight (0) or crossed (1).
// RULE2: With auto crossover on, hunting happens only if the strap is high, else straight; both enabled at reset.
// RULE3: In auto mode the pairs swap while no link; straight sends on A, crossed sends on B.
// RULE4: Crossover runs apart from negotiation and settles before negotiation may start.
// RULE5: Power-down is considered only while link is down and transmit enable is low.
// RULE6: After those conditions hold for 32 s, deep power-down is entered.
// RULE7: In power-down only the sections whose select bits are set are shut off.
// RULE8: Each status pin shows one event picked by the LED register.
// RULE9: The strap pins are inputs in hardware reset, sampled at release, then outputs.
// RULE10: A software reset leaves the strap pins sampled and driving.
// RULE11: A driven strap pin shows the inverse of its sampled level while its event is on.
// RULE12: The board pulls every strap pin; the sampled levels form the management address.
// RULE13: A management address of zero puts the MAC-side outputs in high impedance.
// RULE14: Register space: 0 control, 1 status, 2-3 id, 4-8 negotiation, 9-15 reserved, 16-31 vendor.
// RULE15: Power-down ends when line energy appears or transmit enable rises.
// RULE16: Each status pin has its own selector covering all seven events.
`include "pmlc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pmlc_phy_aux #(
	parameter [33:0] DPD_CYCLES  = `PMLC_DPD_CYC,
	parameter [16:0] XO_HUNT_CYC = `PMLC_XO_HUNT_CYC,
	parameter [2:0]  ADDR_HIGH   = 3'h0,
	parameter [15:0] ID_HIGH     = 16'h1234,  // arbitrary value
	parameter [15:0] ID_LOW      = 16'h5670   // arbitrary value
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Management bus
	input  wire        mdc,
	input  wire        mdio_in,
	output reg         mdio_out,
	output reg         mdio_oe,
	// Strap / status pins
	input  wire        strap_status_pin_0_in,
	output reg         strap_status_pin_0_out,
	output reg         strap_status_pin_0_oe,
	input  wire        strap_status_pin_1_in,
	output reg         strap_status_pin_1_out,
	output reg         strap_status_pin_1_oe,
	// Line and MAC status
	input  wire        auto_crossover_pin,
	input  wire        energy_detect,
	input  wire        link_up,
	input  wire        tx_en,
	input  wire        rx_active,
	input  wire        collision,
	input  wire        full_duplex,
	// Control outputs
	output reg         mdi_crossed,
	output wire        an_start_allow,
	output wire        an_restart,
	output wire        speed_100,
	output reg         deep_power_down,
	output wire [4:0]  section_off,
	output wire        mii_hiz,
	output wire [4:0]  phy_addr
);

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_HDR  = 2'h1;
	localparam [1:0] S_TA   = 2'h2;
	localparam [1:0] S_DATA = 2'h3;

	// Register state
	reg  [15:0] ctrl_q;
	reg  [15:0] adv_q;
	reg  [15:0] npt_q;
	reg  [15:0] xo_q;
	reg  [15:0] led_q;
	reg  [15:0] pwr_q;
	reg         link_ll_q;
	reg  [1:0]  strap_q;
	reg         strap_ok_q;
	// Management engine
	reg         mdc_q;
	reg  [1:0]  st_q;
	reg  [5:0]  pre_q;
	reg  [3:0]  cnt_q;
	reg  [15:0] sh_q;
	reg  [4:0]  ra_q;
	reg         rd_q;
	reg         we_q;
	reg  [15:0] wd_q;
	reg         re_q;
	reg  [15:0] rd_word;
	// Crossover, power-down and soft reset pulse
	reg  [16:0] hunt_q;
	reg  [33:0] idle_q;
	reg         rst_pulse;

	wire        mdc_rise = mdc & ~mdc_q;
	wire        mdc_fall = ~mdc & mdc_q;
	wire [12:0] hdr      = {sh_q[11:0], mdio_in};
	wire        soft_rst = we_q & (ra_q == `PMLC_REG_CTRL) &
	                       wd_q[`PMLC_CTL_RESET];
	wire        auto_on  = xo_q[`PMLC_XO_AUTO] & auto_crossover_pin;

	// ==========================================================
	// Strap capture at reset release, then drive
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_q    <= 2'h0;
			strap_ok_q <= 1'b0;
		end else if (!strap_ok_q) begin
			strap_q    <= {strap_status_pin_1_in,
			               strap_status_pin_0_in};  // RULE9
			strap_ok_q <= 1'b1;
		end
	end

	assign phy_addr = {ADDR_HIGH, strap_q};  // RULE12
	assign mii_hiz  = (strap_ok_q & (phy_addr == 5'h00)) |
	                  ctrl_q[`PMLC_CTL_ISOLATE];  // RULE13

	// Event selector shared by both pins
	function ev_sel;
		input [2:0] sel;
		begin
			case (sel)
				`PMLC_EV_LINK:   ev_sel = link_up;
				`PMLC_EV_ACT:    ev_sel = tx_en | rx_active;
				`PMLC_EV_TX:     ev_sel = tx_en;
				`PMLC_EV_RX:     ev_sel = rx_active;
				`PMLC_EV_COL:    ev_sel = collision;
				`PMLC_EV_SPEED:  ev_sel = ctrl_q[`PMLC_CTL_SPEED];
				`PMLC_EV_DUPLEX: ev_sel = full_duplex;
				default:         ev_sel = 1'b0;
			endcase
		end
	endfunction

	// Status pin drive; soft reset does not touch this
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_status_pin_0_out <= 1'b0;
			strap_status_pin_1_out <= 1'b0;
			strap_status_pin_0_oe  <= 1'b0;
			strap_status_pin_1_oe  <= 1'b0;
		end else begin
			strap_status_pin_0_oe  <= strap_ok_q;  // RULE9 RULE10
			strap_status_pin_1_oe  <= strap_ok_q;  // RULE9 RULE10
			strap_status_pin_0_out <= strap_q[0] ^
			                          ev_sel(led_q[2:0]);  // RULE8 RULE11 RULE16
			strap_status_pin_1_out <= strap_q[1] ^
			                          ev_sel(led_q[6:4]);  // RULE8 RULE11 RULE16
		end
	end

	// ==========================================================
	// Crossover: forced, straight, or hunt while no link
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdi_crossed <= 1'b0;
			hunt_q      <= 17'h0;
		end else if (!xo_q[`PMLC_XO_AUTO]) begin
			mdi_crossed <= xo_q[`PMLC_XO_FORCE];  // RULE1
			hunt_q      <= 17'h0;
		end else if (!auto_crossover_pin) begin
			mdi_crossed <= 1'b0;  // RULE2
			hunt_q      <= 17'h0;
		end else if (link_up || energy_detect) begin
			hunt_q      <= 17'h0;
		end else if (hunt_q >= XO_HUNT_CYC - 17'h1) begin
			mdi_crossed <= ~mdi_crossed;  // RULE3
			hunt_q      <= 17'h0;
		end else begin
			hunt_q      <= hunt_q + 17'h1;
		end
	end

	// With auto crossover on, negotiation waits until a pair sees the partner
	assign an_start_allow = ctrl_q[`PMLC_CTL_ANEN] &
	                        (~auto_on | energy_detect | link_up);  // RULE4
	assign an_restart     = we_q & (ra_q == `PMLC_REG_CTRL) &
	                        wd_q[`PMLC_CTL_RESTART];
	assign speed_100      = ctrl_q[`PMLC_CTL_SPEED];

	// ==========================================================
	// Deep power-down timer
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			idle_q          <= 34'h0;
			deep_power_down <= 1'b0;
		end else if (energy_detect || tx_en) begin
			idle_q          <= 34'h0;
			deep_power_down <= 1'b0;  // RULE15
		end else if (link_up) begin
			idle_q          <= 34'h0;  // RULE5
		end else if (idle_q >= DPD_CYCLES - 34'h1) begin
			deep_power_down <= 1'b1;  // RULE6
		end else begin
			idle_q          <= idle_q + 34'h1;  // RULE5
		end
	end

	assign section_off = deep_power_down ?
	       pwr_q[`PMLC_PWR_SEL_HI:`PMLC_PWR_SEL_LO] : 5'h00;  // RULE7

	// ==========================================================
	// Management frame engine
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdc_q    <= 1'b0;
			st_q     <= S_IDLE;
			pre_q    <= 6'h0;
			cnt_q    <= 4'h0;
			sh_q     <= 16'h0;
			ra_q     <= 5'h0;
			rd_q     <= 1'b0;
			we_q     <= 1'b0;
			wd_q     <= 16'h0;
			re_q     <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe  <= 1'b0;
		end else begin
			mdc_q <= mdc;
			we_q  <= 1'b0;
			re_q  <= 1'b0;
			case (st_q)
				S_IDLE: begin
					if (mdc_rise && mdio_in) begin
						if (pre_q != `PMLC_PRE_ONES)
							pre_q <= pre_q + 6'h1;
					end else if (mdc_rise) begin
						pre_q <= 6'h0;
						cnt_q <= 4'h0;
						sh_q  <= 16'h0;
						if (pre_q == `PMLC_PRE_ONES)
							st_q <= S_HDR;
					end
				end
				S_HDR: begin
					if (mdc_rise) begin
						sh_q  <= {sh_q[14:0], mdio_in};
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'hc) begin
							cnt_q <= 4'h0;
							ra_q  <= hdr[4:0];
							rd_q  <= hdr[11:10] == `PMLC_OP_READ;
							re_q  <= hdr[11:10] == `PMLC_OP_READ;
							if (hdr[12] && hdr[9:5] == phy_addr &&
							    (hdr[11:10] == `PMLC_OP_READ ||
							     hdr[11:10] == `PMLC_OP_WRITE))
								st_q <= S_TA;
							else
								st_q <= S_IDLE;
						end
					end
				end
				S_TA: begin
					if (re_q)
						sh_q <= rd_word;
					if (mdc_fall && rd_q && cnt_q == 4'h1) begin
						mdio_oe  <= 1'b1;
						mdio_out <= 1'b0;
					end
					if (mdc_rise) begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h1) begin
							cnt_q <= 4'h0;
							st_q  <= S_DATA;
						end
					end
				end
				default: begin
					if (mdc_fall && rd_q) begin
						mdio_out <= sh_q[15];
						sh_q     <= {sh_q[14:0], 1'b0};
					end
					if (mdc_rise) begin
						if (!rd_q)
							sh_q <= {sh_q[14:0], mdio_in};
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'hf) begin
							st_q    <= S_IDLE;
							mdio_oe <= 1'b0;
							we_q    <= ~rd_q;
							wd_q    <= {sh_q[14:0], mdio_in};
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Read decode of the register space
	always @* begin
		case (ra_q)
			`PMLC_REG_CTRL:  rd_word = ctrl_q;  // RULE14
			`PMLC_REG_STAT:  rd_word = `PMLC_STAT_CONST |
			                  {13'h0, link_ll_q, 2'h0};
			`PMLC_REG_ID_HI: rd_word = ID_HIGH;
			`PMLC_REG_ID_LO: rd_word = ID_LOW;
			`PMLC_REG_ADV:   rd_word = adv_q;
			`PMLC_REG_NPT:   rd_word = npt_q;
			`PMLC_REG_XOVER: rd_word = xo_q;
			`PMLC_REG_LED:   rd_word = led_q;
			`PMLC_REG_PWR:   rd_word = pwr_q |
			                  {15'h0, deep_power_down};
			default:         rd_word = 16'h0000;
		endcase
	end

	// ==========================================================
	// Register writes, soft reset restores defaults
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rst_pulse <= 1'b0;
			ctrl_q    <= `PMLC_CTL_RST_VAL;
			adv_q     <= `PMLC_ADV_RST_VAL;
			npt_q     <= `PMLC_NPT_RST_VAL;
			xo_q      <= `PMLC_XO_RST_VAL;  // RULE2
			led_q     <= `PMLC_LED_RST_VAL;
			pwr_q     <= `PMLC_PWR_RST_VAL;
		end else begin
			rst_pulse <= soft_rst;
			if (rst_pulse) begin
				ctrl_q <= `PMLC_CTL_RST_VAL;  // RULE10
				adv_q  <= `PMLC_ADV_RST_VAL;
				npt_q  <= `PMLC_NPT_RST_VAL;
				xo_q   <= `PMLC_XO_RST_VAL;
				led_q  <= `PMLC_LED_RST_VAL;
				pwr_q  <= `PMLC_PWR_RST_VAL;
			end else if (we_q && !soft_rst) begin
				case (ra_q)
					`PMLC_REG_CTRL:  ctrl_q <= wd_q & `PMLC_CTL_WMASK;
					`PMLC_REG_ADV:   adv_q  <= wd_q;
					`PMLC_REG_NPT:   npt_q  <= wd_q;
					`PMLC_REG_XOVER: xo_q   <= wd_q & 16'h0300;
					`PMLC_REG_LED:   led_q  <= wd_q & 16'h0077;
					`PMLC_REG_PWR:   pwr_q  <= wd_q & 16'h01f0;
					default:         ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// Link status latches low until the status register is read
	always @(posedge mclk or posedge rst) begin
		if (rst)
			link_ll_q <= 1'b0;
		else if (re_q && ra_q == `PMLC_REG_STAT)
			link_ll_q <= link_up;
		else
			link_ll_q <= link_ll_q & link_up;
	end

endmodule

`default_nettype wire

// ==== tb/pmlc_phy_aux_assertions.sv ====
// Purpose: port checks of pmlc_phy_aux
// Assumes: one mclk domain, rst async high
// Notes:   bound to every instance
`timescale 1ns/1ps
`default_nettype none
module pmlc_phy_aux_chk #(
	parameter [33:0] DPD_CYCLES = 34'd50
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Observed ports
	input wire logic       strap_status_pin_0_oe,
	input wire logic       link_up,
	input wire logic       tx_en,
	input wire logic       energy_detect,
	input wire logic       mdi_crossed,
	input wire logic       deep_power_down,
	input wire logic [4:0] section_off,
	input wire logic       mii_hiz,
	input wire logic [4:0] phy_addr
);
	// ==========================================================
	// Quiet line cycle count
	logic [33:0] quiet_q;
	always @(posedge mclk or posedge rst) begin
		if (rst)
			quiet_q <= 34'h0;
		else if (link_up || tx_en || energy_detect)
			quiet_q <= 34'h0;
		else
			quiet_q <= quiet_q + 34'h1;
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ==========================================================
	// Properties
	property p_hiz;
		strap_status_pin_0_oe && phy_addr == 5'h00 |-> mii_hiz;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("mii not isolated at address zero");
	property p_oe_rise;
		$fell(rst) |-> !strap_status_pin_0_oe ##[1:2] strap_status_pin_0_oe;
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("strap pin not turned to output");
	property p_oe_hold;
		strap_status_pin_0_oe |=> strap_status_pin_0_oe;
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("strap pin output dropped");
	property p_addr;
		strap_status_pin_0_oe && $past(strap_status_pin_0_oe)
			|-> $stable(phy_addr);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address changed after sampling");
	property p_sec;
		!deep_power_down |-> section_off == 5'h00;
	endproperty
	a_sec: assert property (p_sec)
		else $error("section off outside power-down");
	property p_exit;
		deep_power_down && (energy_detect || tx_en) |=> !deep_power_down;
	endproperty
	a_exit: assert property (p_exit)
		else $error("power-down not left");
	property p_delay;
		$rose(deep_power_down) |-> quiet_q >= DPD_CYCLES - 34'd2
			&& quiet_q <= DPD_CYCLES + 34'd2;
	endproperty
	a_delay: assert property (p_delay)
		else $error("power-down entry time wrong");
	property p_xo;
		link_up && $past(link_up) |-> $stable(mdi_crossed);
	endproperty
	a_xo: assert property (p_xo)
		else $error("mapping swapped with link up");
endmodule
bind pmlc_phy_aux pmlc_phy_aux_chk #(.DPD_CYCLES(DPD_CYCLES)) i_chk (
	.mclk(mclk), .rst(rst), .strap_status_pin_0_oe(strap_status_pin_0_oe),
	.link_up(link_up), .tx_en(tx_en), .energy_detect(energy_detect),
	.mdi_crossed(mdi_crossed), .deep_power_down(deep_power_down),
	.section_off(section_off), .mii_hiz(mii_hiz), .phy_addr(phy_addr));
`default_nettype wire

// ==== tb/pmlc_sta_model.sv ====
// Purpose: management master making mdc/mdio frames
// Assumes: mdc phases of 4 mclk, mdio pulled up
// Notes:   mdc rests low between frames
`timescale 1ns/1ps
`default_nettype none
module pmlc_sta_model (
	// Clock
	input  wire logic        mclk,
	// Management pins
	output var  logic        mdc,
	output wire logic        mdio_in,
	input  wire logic        mdio_out,
	input  wire logic        mdio_oe,
	// Read result
	output var  logic        rd_v,
	output var  logic [15:0] rd_d
);
	logic drv_en;
	logic drv_val;
	// Wire level: device, master, else pull-up
	assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b1;
		rd_v = 1'b0;
		rd_d = 16'h0;
	end
	// One mdc period, sampled just before the rise; the device
	// changes its data on falls and lets go right after the last rise
	task automatic bit_io(input logic en, input logic b, output logic s);
		drv_en = en;
		drv_val = b;
		repeat (4) @(negedge mclk);
		s = mdio_in;
		mdc = 1'b1;
		repeat (4) @(negedge mclk);
		mdc = 1'b0;
	endtask
	// Whole frame, released from turnaround on reads
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd);
		logic [63:0] f;
		logic s;
		logic rd;
		f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd = (op == 2'h2);
		for (int i = 63; i >= 0; i--) begin
			bit_io(!(rd && i < 18), f[i], s);
			if (i < 16)
				rd_d[i] = s;
		end
		drv_en = 1'b0;
		repeat (4) @(negedge mclk);
		rd_v = rd;
		@(negedge mclk);
		rd_v = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/pmlc_phy_aux_tb.sv ====
// Purpose: self-checking bench of pmlc_phy_aux
// Assumes: board pulls on strap pins, short power-down count
// Notes:   expected words queue up, a monitor pops them
`timescale 1ns/1ps
`default_nettype none
module pmlc_phy_aux_tb;
	logic mclk, rst, mdc, mdio_in, mdio_out, mdio_oe, rd_v;
	logic strap_status_pin_0_in, strap_status_pin_0_out;
	logic strap_status_pin_0_oe, strap_status_pin_1_in;
	logic strap_status_pin_1_out, strap_status_pin_1_oe;
	logic auto_crossover_pin, energy_detect, link_up, tx_en;
	logic rx_active, collision, full_duplex, mdi_crossed;
	logic an_start_allow, deep_power_down, mii_hiz;
	logic [4:0] section_off, phy_addr;
	logic [15:0] rd_d, tog;
	logic [31:0] q[$];
	int n_fail, n_compared;
	logic obs_v, use_tog, pl0, pl1, ev;
	logic [6:0] evs;
	logic [4:0] ra_t [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
		5'h07, 5'h09, 5'h10, 5'h13, 5'h14, 5'h18};
	logic [15:0] rv_t [11] = '{16'h3100, 16'h7809, 16'h0a5c, 16'h3c01,
		16'h01e1, 16'h2001, 16'h0, 16'h0, 16'h0200, 16'h0010, 16'h0};
	wire [4:0] pa = {3'h0, pl1, pl0};
	wire [15:0] obs = use_tog ? tog : {phy_addr, section_off,
		deep_power_down, mii_hiz, mdi_crossed, an_start_allow,
		strap_status_pin_1_out, strap_status_pin_0_out};
	// Board pulls where the pin is not driven
	assign strap_status_pin_0_in = strap_status_pin_0_oe ?
		strap_status_pin_0_out : pl0;
	assign strap_status_pin_1_in = strap_status_pin_1_oe ?
		strap_status_pin_1_out : pl1;
	pmlc_phy_aux #(.DPD_CYCLES(34'd50), .XO_HUNT_CYC(17'd20),
		.ID_HIGH(16'h0a5c), .ID_LOW(16'h3c01)) i_pmlc_phy_aux (.mclk,
		.rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .strap_status_pin_0_in,
		.strap_status_pin_0_out, .strap_status_pin_0_oe,
		.strap_status_pin_1_in, .strap_status_pin_1_out,
		.strap_status_pin_1_oe, .auto_crossover_pin, .energy_detect,
		.link_up, .tx_en, .rx_active, .collision, .full_duplex,
		.mdi_crossed, .an_start_allow, .an_restart(), .speed_100(),
		.deep_power_down, .section_off, .mii_hiz, .phy_addr);
	pmlc_sta_model i_pmlc_sta_model (.mclk, .mdc, .mdio_in, .mdio_out,
		.mdio_oe, .rd_v, .rd_d);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Compare one result with the oldest note
	task automatic check_word(input logic [15:0] w);
		logic [31:0] e;
		e = q.pop_front();
		n_compared++;
		if ((w & e[31:16]) !== e[15:0]) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, w & e[31:16], e[15:0]);
		end
	endtask
	always @(posedge mclk) begin
		if (rd_v || obs_v)
			check_word(rd_v ? rd_d : obs);
	end
	task automatic look(input logic [15:0] m, input logic [15:0] v);
		q.push_back({m, v});
		obs_v = 1'b1;
		@(negedge mclk);
		obs_v = 1'b0;
		use_tog = 1'b0;
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] v);
		q.push_back({16'hffff, v});
		i_pmlc_sta_model.xfer(2'h2, pa, ra, 16'h0);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		i_pmlc_sta_model.xfer(2'h1, pa, ra, d);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	// Count mapping swaps over n cycles
	task automatic count_tog(input int n);
		logic xl;
		xl = mdi_crossed;
		tog = 16'h0;
		repeat (n) begin
			@(negedge mclk);
			if (mdi_crossed !== xl)
				tog = tog + 16'h1;
			xl = mdi_crossed;
		end
		use_tog = 1'b1;
	endtask
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#600000;
		n_fail++;
		complete_run();
	end
	// Main sequence
	initial begin
		{rst, pl0, pl1, auto_crossover_pin, energy_detect} = 5'b11011;
		{link_up, tx_en, rx_active, collision, full_duplex} = 5'h0;
		{obs_v, use_tog, tog} = 18'h0;
		void'($urandom(32'hd3b4b39c));
		@(negedge mclk);
		do_reset();
		look(16'hf810, 16'h0800);
		wr(5'h09, 16'hffff);
		for (int i = 0; i < 11; i++)
			rd(ra_t[i], rv_t[i]);
		for (int i = 0; i < 7; i++) begin
			wr(5'h14, {9'h0, i[2:0], 1'b0, i[2:0]});
			{link_up, tx_en, rx_active, collision, full_duplex} = 5'($urandom);
			repeat (3) @(negedge mclk);
			evs = {full_duplex, 1'b1, collision, rx_active, tx_en,
				tx_en | rx_active, link_up};
			ev = evs[i];
			look(16'h0003, {14'h0, pl1 ^ ev, pl0 ^ ev});
		end
		{link_up, tx_en, rx_active, collision, full_duplex} = 5'h0;
		wr(5'h00, 16'h8000);
		repeat (5) @(negedge mclk);
		look(16'hf800, {pa, 11'h0});
		rd(5'h14, 16'h0010);
		wr(5'h13, 16'h0100);
		look(16'h0008, 16'h0008);
		wr(5'h13, 16'h0000);
		look(16'h0008, 16'h0000);
		auto_crossover_pin = 1'b0;
		wr(5'h13, 16'h0200);
		energy_detect = 1'b0;
		repeat (30) @(negedge mclk);
		look(16'h0008, 16'h0000);
		auto_crossover_pin = 1'b1;
		repeat (3) @(negedge mclk);
		look(16'h0004, 16'h0000);
		count_tog(100);
		look(16'hffff, 16'd5);
		link_up = 1'b1;
		repeat (3) @(negedge mclk);
		look(16'h0004, 16'h0004);
		count_tog(60);
		look(16'hffff, 16'd0);
		link_up = 1'b0;
		tx_en = 1'b1;
		wr(5'h18, 16'h0150);
		tx_en = 1'b0;
		repeat (40) @(negedge mclk);
		look(16'h07e0, 16'h0000);
		repeat (20) @(negedge mclk);
		look(16'h07e0, 16'h0560);
		energy_detect = 1'b1;
		@(negedge mclk);
		look(16'h07e0, 16'h0000);
		energy_detect = 1'b0;
		repeat (5) begin
			tx_en = ~tx_en;
			repeat (30) @(negedge mclk);
		end
		look(16'h0020, 16'h0000);
		{pl0, pl1} = 2'b00;
		do_reset();
		look(16'hf810, 16'h0010);
		complete_run();
	end
endmodule
`default_nettype wire
